// ===== verilog/sdb_pkg.sv
// Shared constants and carriers for the SDRAM command-side init, mode and burst block.
// Assumes the command pins are driven by controller logic on the same clock.
package sdb_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SDB_ADDR_STATUS = 4'h0;
  localparam logic [3:0] SDB_ADDR_MODE = 4'h4;
  localparam logic [3:0] SDB_ADDR_EXT = 4'h8;
  localparam logic [3:0] SDB_ADDR_CONTROL = 4'hC;
  localparam logic [1:0] SDB_CONTROL_RESET = 2'h1;
  localparam int SDB_STATUS_ERR_BIT = 4;

  // ---------------------------------------------------------------------------
  // Mode register layout and encodings
  // ---------------------------------------------------------------------------
  localparam int SDB_BL_LSB = 0;
  localparam int SDB_BT_BIT = 3;
  localparam int SDB_LAT_LSB = 4;
  localparam int SDB_OPMODE_LSB = 7;
  localparam logic [2:0] SDB_BL_2 = 3'h1;
  localparam logic [2:0] SDB_BL_4 = 3'h2;
  localparam logic [2:0] SDB_BL_8 = 3'h3;
  localparam logic [2:0] SDB_BL_16 = 3'h4;
  localparam logic [2:0] SDB_LAT_2 = 3'h2;
  localparam logic [2:0] SDB_LAT_3 = 3'h3;
  localparam logic [13:0] SDB_MODE_RESET = 14'h0000;
  localparam logic [1:0] SDB_BA_STD = 2'h0;
  localparam logic [1:0] SDB_BA_EXT = 2'h2;
  localparam logic [1:0] SDB_REFRESH_NEEDED = 2'h2;
  localparam int SDB_PRE_ALL_BIT = 10;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [13:0] addr;
  } sdb_cmd_pins_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic last;
    logic [1:0] bank;
    logic [9:0] column;
  } sdb_beat_t;

  typedef enum {
    SDB_CMD_NOP,
    SDB_CMD_ACTIVE,
    SDB_CMD_READ,
    SDB_CMD_WRITE,
    SDB_CMD_PRECHARGE,
    SDB_CMD_REFRESH,
    SDB_CMD_LOAD_MODE,
    SDB_CMD_BURST_STOP
  } sdb_cmd_t;

  typedef enum {
    SDB_ST_POWERUP,
    SDB_ST_PRECHARGED,
    SDB_ST_READY
  } sdb_init_t;

endpackage : sdb_pkg

// ===== verilog/sdb_core.sv
// SDRAM device-side command tracker: power-up sequence check, mode registers, burst columns.
// Assumes command pins come from controller logic on i_clock and a classic Wishbone master.
// Rules from the document
// RULE1: Controller raises clock enable before clock.
// RULE2: Or raises clock enable before first command.
// RULE3: Controller waits 200us issuing only NOPs.
// RULE4: Controller precharges all banks, then waits.
// RULE5: Controller issues two auto refreshes, waits each.
// RULE6: Controller loads both mode registers, waits each.
// RULE7: Commands accepted only after full initialization.
// RULE8: Controller reinitializes after any power loss.
// RULE9: Load with bank bits 00 writes mode.
// RULE10: Mode kept until reload or deep power-down.
// RULE11: Mode reload never touches the array.
// RULE12: Controller loads mode only when idle.
// RULE13: Controller avoids reserved mode encodings.
// RULE14: Burst sizes 2, 4, 8, 16 both ways.
// RULE15: Burst wraps inside aligned burst-size block.
// RULE16: Mode bit selects sequential or interleaved.
// RULE17: Sequential adds step; interleaved XORs step.
// RULE18: Order from size, type and start column.
// RULE19: Read latency setting gives 2 or 3 cycles.
// RULE20: Controller keeps mode bits 7 and up zero.
// RULE21: Load with bank bits 10 writes extended.
// RULE22: Controller reinitializes after deep power-down exit.
// RULE23: Mode fields: size 2:0, type 3, latency 6:4.
// RULE24: Controller rounds waits up to whole cycles.
`timescale 1ns/100ps
module sdb_core import sdb_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Command pins from the controller
  input wire sdb_cmd_pins_t i_cmd,
  // Burst column stream
  output sdb_beat_t o_beat,
  output logic o_ready,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic sdb_cmd_t decode_cmd(input sdb_cmd_pins_t p);
    logic [2:0] rcw;
    rcw = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) begin
      return SDB_CMD_NOP;
    end
    case (rcw)
      3'h3: return SDB_CMD_ACTIVE;
      3'h5: return SDB_CMD_READ;
      3'h4: return SDB_CMD_WRITE;
      3'h2: return SDB_CMD_PRECHARGE;
      3'h1: return SDB_CMD_REFRESH;
      3'h0: return SDB_CMD_LOAD_MODE;
      3'h6: return SDB_CMD_BURST_STOP;
      default: return SDB_CMD_NOP;
    endcase
  endfunction : decode_cmd

  // Burst size minus one; zero marks a reserved size code.
  function automatic logic [3:0] size_mask(input logic [2:0] code);
    case (code)
      SDB_BL_2: return 4'h1;
      SDB_BL_4: return 4'h3;
      SDB_BL_8: return 4'h7;
      SDB_BL_16: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : size_mask

  function automatic logic [9:0] burst_column(input logic [9:0] start, input logic [3:0] step,
                                              input logic [3:0] mask, input logic interleave);
    logic [3:0] low;
    low = interleave ? (start[3:0] ^ step) : 4'(start[3:0] + step);
    return (start & ~{6'h00, mask}) | {6'h00, low & mask};
  endfunction : burst_column

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  logic cke_prev_reg;
  sdb_cmd_t cmd;
  logic cmd_live;
  logic dpd_entry;
  logic [31:0] control_reg;
  sdb_init_t init_reg;

  assign cmd = decode_cmd(i_cmd);
  assign cmd_live = cke_prev_reg && i_cmd.cke;
  assign dpd_entry = cke_prev_reg && !i_cmd.cke && cmd == SDB_CMD_BURST_STOP
                     && init_reg == SDB_ST_READY;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= i_cmd.cke;
    end
  end

  // ---------------------------------------------------------------------------
  // Initialization tracking
  // ---------------------------------------------------------------------------
  logic [1:0] refresh_cnt_reg;
  logic std_loaded_reg;
  logic ext_loaded_reg;
  logic err_reg;
  logic load_std;
  logic load_ext;
  logic early_access;
  logic err_clear;

  assign load_std = cmd_live && cmd == SDB_CMD_LOAD_MODE && i_cmd.ba == SDB_BA_STD; // RULE9
  assign load_ext = cmd_live && cmd == SDB_CMD_LOAD_MODE && i_cmd.ba == SDB_BA_EXT; // RULE21
  assign early_access = cmd_live && init_reg != SDB_ST_READY
                        && (cmd == SDB_CMD_READ || cmd == SDB_CMD_WRITE || cmd == SDB_CMD_ACTIVE);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_reg <= SDB_ST_POWERUP;
      refresh_cnt_reg <= 2'h0;
    end else if (dpd_entry) begin
      init_reg <= SDB_ST_POWERUP; // RULE10
      refresh_cnt_reg <= 2'h0;
    end else begin
      case (init_reg)
        SDB_ST_POWERUP: begin
          if (cmd_live && cmd == SDB_CMD_PRECHARGE && i_cmd.addr[SDB_PRE_ALL_BIT]) begin
            init_reg <= SDB_ST_PRECHARGED;
          end
        end
        SDB_ST_PRECHARGED: begin
          if (cmd_live && cmd == SDB_CMD_REFRESH && refresh_cnt_reg != SDB_REFRESH_NEEDED) begin
            refresh_cnt_reg <= 2'(refresh_cnt_reg + 2'h1);
          end
          if (refresh_cnt_reg == SDB_REFRESH_NEEDED && std_loaded_reg && ext_loaded_reg) begin
            init_reg <= SDB_ST_READY; // RULE7
          end
        end
        SDB_ST_READY: init_reg <= SDB_ST_READY;
        default: init_reg <= SDB_ST_POWERUP;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_reg <= 1'b0;
    end else if (early_access) begin
      err_reg <= 1'b1; // Set wins over a simultaneous software clear.
    end else if (err_clear) begin
      err_reg <= 1'b0;
    end
  end

  assign o_ready = init_reg == SDB_ST_READY;

  // ---------------------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------------------
  logic [13:0] mode_reg;
  logic [13:0] ext_reg;
  logic [3:0] mask;
  logic [2:0] lat;
  logic lat_ok;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= SDB_MODE_RESET;
      std_loaded_reg <= 1'b0;
    end else if (dpd_entry) begin
      mode_reg <= SDB_MODE_RESET; // RULE10
      std_loaded_reg <= 1'b0;
    end else if (load_std) begin
      mode_reg <= i_cmd.addr; // RULE9
      std_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_reg <= SDB_MODE_RESET;
      ext_loaded_reg <= 1'b0;
    end else if (dpd_entry) begin
      ext_reg <= SDB_MODE_RESET; // RULE10
      ext_loaded_reg <= 1'b0;
    end else if (load_ext) begin
      ext_reg <= i_cmd.addr; // RULE21
      ext_loaded_reg <= 1'b1;
    end
  end

  assign mask = size_mask(mode_reg[SDB_BL_LSB +: 3]); // RULE23 RULE14
  assign lat = mode_reg[SDB_LAT_LSB +: 3]; // RULE23
  assign lat_ok = lat == SDB_LAT_2 || lat == SDB_LAT_3;

  // ---------------------------------------------------------------------------
  // Burst column generator
  // ---------------------------------------------------------------------------
  // A burst with a reserved size or latency code is dropped rather than guessed.
  logic burst_go;
  logic active_reg;
  logic wr_reg;
  logic delay_reg;
  logic [3:0] step_reg;
  logic [9:0] start_reg;
  logic [1:0] bank_reg;

  assign burst_go = cmd_live && o_ready && mask != 4'h0 && lat_ok
                    && (cmd == SDB_CMD_READ || (cmd == SDB_CMD_WRITE)); // RULE7 RULE11

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_reg <= 1'b0;
      wr_reg <= 1'b0;
      delay_reg <= 1'b0;
      step_reg <= 4'h0;
      start_reg <= 10'h000;
      bank_reg <= 2'h0;
    end else if (burst_go) begin
      // A new access truncates any burst still running.
      active_reg <= 1'b1;
      wr_reg <= cmd == SDB_CMD_WRITE;
      delay_reg <= cmd == SDB_CMD_READ && lat == SDB_LAT_3; // RULE19
      step_reg <= 4'h0;
      start_reg <= i_cmd.addr[9:0]; // RULE18
      bank_reg <= i_cmd.ba;
    end else if (active_reg && delay_reg) begin
      delay_reg <= 1'b0;
    end else if (active_reg) begin
      step_reg <= 4'(step_reg + 4'h1);
      active_reg <= step_reg != mask;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_beat <= '0;
    end else begin
      o_beat.valid <= active_reg && !delay_reg;
      o_beat.write <= wr_reg;
      o_beat.last <= step_reg == mask;
      o_beat.bank <= bank_reg;
      o_beat.column <= burst_column(start_reg, step_reg, mask, mode_reg[SDB_BT_BIT]); // RULE15 RULE16 RULE17
    end
  end

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  logic wb_hit;
  logic [31:0] rd_value;

  assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign err_clear = wb_hit && i_wb_we && i_wb_adr == SDB_ADDR_STATUS && i_wb_sel[0]
                     && i_wb_dat[SDB_STATUS_ERR_BIT];

  always_comb begin
    rd_value = 32'h0000_0000;
    case (i_wb_adr)
      SDB_ADDR_STATUS: rd_value = {26'h0, err_reg, ext_loaded_reg, std_loaded_reg,
                                   refresh_cnt_reg == SDB_REFRESH_NEEDED,
                                   init_reg != SDB_ST_POWERUP, o_ready};
      SDB_ADDR_MODE: rd_value = {18'h0, mode_reg};
      SDB_ADDR_EXT: rd_value = {18'h0, ext_reg};
      SDB_ADDR_CONTROL: rd_value = control_reg;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_hit;
      o_wb_dat <= wb_hit ? rd_value : 32'h0000_0000;
    end
  end

  // Control bit 0 is a scratch enable kept for software; bit 1 is spare.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_reg <= {30'h0, SDB_CONTROL_RESET};
    end else if (wb_hit && i_wb_we && i_wb_adr == SDB_ADDR_CONTROL && i_wb_sel[0]) begin
      control_reg <= {30'h0, i_wb_dat[1:0]};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_read_lat3;
    burst_go && cmd == SDB_CMD_READ && lat == SDB_LAT_3;
  endsequence
  sequence s_read_lat2;
    burst_go && cmd == SDB_CMD_READ && lat == SDB_LAT_2;
  endsequence

  a_no_early_burst: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE7
    !o_ready |=> !active_reg || $past(active_reg)) else $error("burst before ready");
  a_std_load: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE9
    load_std && !dpd_entry |=> mode_reg == $past(i_cmd.addr)) else $error("mode not loaded");
  a_ext_load: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE21
    load_ext && !dpd_entry |=> ext_reg == $past(i_cmd.addr)) else $error("ext not loaded");
  a_mode_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE10
    !load_std && !dpd_entry |=> $stable(mode_reg)) else $error("mode changed");
  a_dpd_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE10
    dpd_entry |=> !o_ready && mode_reg == SDB_MODE_RESET) else $error("dpd kept state");
  a_lat_three: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE19
    s_read_lat3 ##1 !burst_go ##1 !burst_go |=> o_beat.valid && !$past(o_beat.valid))
    else $error("latency 3 wrong");
  a_lat_two: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE19
    s_read_lat2 ##1 !burst_go |=> o_beat.valid) else $error("latency 2 wrong");
  a_wrap_block: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE15
    o_beat.valid |-> (o_beat.column & ~{6'h00, mask}) == (start_reg & ~{6'h00, mask}))
    else $error("burst left block");
  a_first_col: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE17
    active_reg && !delay_reg && step_reg == 4'h0 |=> o_beat.column == $past(start_reg))
    else $error("first column wrong");
  a_burst_len: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE14
    o_beat.valid && o_beat.last |-> $past(step_reg) == $past(mask)) else $error("bad length");

endmodule : sdb_core

// ===== dv/sdb_ctrl_model.sv
// Behavioural memory controller that drives the command pins of the SDRAM block.
// Assumes one clock shared with the block; the bench calls its tasks in sequence.
`timescale 1ns/100ps
module sdb_ctrl_model import sdb_pkg::*; #(
  parameter int STARTUP_CYCLES = 4000,
  parameter int GAP_CYCLES = 3
) (
  // Clock
  input wire logic i_clock,
  // Command pins
  output sdb_cmd_pins_t o_cmd
);
  // ---------------------------------------------------------------------------
  // Idle bus
  // ---------------------------------------------------------------------------
  initial begin
    o_cmd = '0;
    o_cmd.cke = 1'b1;
    o_cmd.cs_n = 1'b1;
  end

  // Address lines toggle while deselected so a stale value never looks live.
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge i_clock);
      o_cmd.cs_n <= 1'b1;
      o_cmd.addr <= ~o_cmd.addr;
    end
  endtask : nop

  // One command; it is registered at the edge on which this task returns.
  task automatic cmd(input logic [2:0] rcw, input logic [1:0] ba, input logic [13:0] adr,
                     input logic cke);
    @(posedge i_clock);
    o_cmd <= '{cke: cke, cs_n: 1'b0, ras_n: rcw[2], cas_n: rcw[1], we_n: rcw[0], ba: ba,
               addr: adr};
    @(posedge i_clock);
    o_cmd <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ~ba,
               addr: ~adr};
  endtask : cmd

  // ---------------------------------------------------------------------------
  // Power-up sequence; waits are whole cycles, rounded up
  // ---------------------------------------------------------------------------
  task automatic init(input logic [13:0] std_val, input logic [13:0] ext_val);
    nop(STARTUP_CYCLES);
    cmd(3'b010, 2'h0, 14'h0400, 1'b1);
    nop(GAP_CYCLES);
    repeat (2) begin
      cmd(3'b001, 2'h0, 14'h0000, 1'b1);
      nop(GAP_CYCLES);
    end
    cmd(3'b000, SDB_BA_STD, std_val, 1'b1);
    nop(GAP_CYCLES);
    cmd(3'b000, SDB_BA_EXT, ext_val, 1'b1);
    nop(GAP_CYCLES);
  endtask : init
endmodule : sdb_ctrl_model

// ===== dv/sdb_core_tb.sv
// Self-checking bench for the SDRAM init, mode and burst block.
// Assumes the controller model drives the command pins and the bench is Wishbone master.
`timescale 1ns/100ps
module sdb_core_tb import sdb_pkg::*;;
  typedef struct packed {
    logic [2:0] code;
    logic typ;
    logic [2:0] lat;
    logic wr;
    logic [9:0] start;
  } sdb_tb_row_t;

  logic i_clock, i_rst_n, cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] wdat, o_wb_dat, rd;
  logic o_wb_ack, o_ready;
  sdb_cmd_pins_t cmd;
  sdb_beat_t o_beat;
  int mismatches, compares;
  sdb_tb_row_t rows [8] = '{
    {3'h1, 1'b0, 3'h2, 1'b0, 10'h001}, {3'h2, 1'b0, 3'h2, 1'b0, 10'h005},
    {3'h2, 1'b1, 3'h3, 1'b1, 10'h00D}, {3'h3, 1'b1, 3'h2, 1'b0, 10'h2A5},
    {3'h3, 1'b0, 3'h3, 1'b1, 10'h106}, {3'h4, 1'b0, 3'h3, 1'b0, 10'h3F7},
    {3'h4, 1'b1, 3'h2, 1'b1, 10'h019}, {3'h1, 1'b1, 3'h3, 1'b0, 10'h000}};

  sdb_ctrl_model #(.STARTUP_CYCLES(40), .GAP_CYCLES(3)) ctrl_u (.i_clock(i_clock), .o_cmd(cmd));
  sdb_core dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd(cmd), .o_beat(o_beat),
    .o_ready(o_ready), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Classic single cycle; ack is sampled at the rising edge and the request held to that edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    i = 0;
    do begin
      @(posedge i_clock);
      i++;
    end while (o_wb_ack !== 1'b1 && i < 50);
    if (o_wb_ack !== 1'b1) begin
      mismatches++;
      results();
    end
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic no_beats();
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge i_clock);
      if (o_beat.valid !== 1'b0) begin
        seen = 1'b1;
      end
    end
    check(seen, 0);
  endtask : no_beats

  task automatic burst(input sdb_tb_row_t r);
    int n, i;
    logic [9:0] mask, low, col;
    n = 1 << r.code;
    mask = 10'(n - 1);
    ctrl_u.cmd(3'b000, SDB_BA_STD, {7'h00, r.lat, r.typ, r.code}, 1'b1);
    ctrl_u.nop(3);
    wb(1'b0, SDB_ADDR_MODE, 32'h0);
    check(rd, {25'h0, r.lat, r.typ, r.code});
    ctrl_u.cmd(r.wr ? 3'b100 : 3'b101, 2'h1, {4'h0, r.start}, 1'b1);
    i = 0;
    while (o_beat.valid !== 1'b1 && i < 8) begin
      @(negedge i_clock);
      i++;
    end
    check(i, r.wr ? 2 : r.lat);
    for (int k = 0; k < n; k++) begin
      low = r.typ ? (r.start ^ 10'(k)) : (r.start + 10'(k));
      col = (r.start & ~mask) | (low & mask);
      check({o_beat.valid, o_beat.write, o_beat.last, o_beat.bank, o_beat.column},
            {1'b1, r.wr, 1'(k == n - 1), 2'h1, col});
      @(negedge i_clock);
    end
    check(o_beat.valid, 0);
  endtask : burst

  // ---------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    mismatches++;
    results();
  end

  initial begin
    {i_rst_n, cyc, stb, we, adr, sel, wdat} = '0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    check(o_ready, 0);
    wb(1'b0, SDB_ADDR_MODE, 32'h0);
    check(rd, 32'(SDB_MODE_RESET));
    wb(1'b0, SDB_ADDR_CONTROL, 32'h0);
    check(rd, 32'(SDB_CONTROL_RESET));
    ctrl_u.cmd(3'b101, 2'h0, 14'h0000, 1'b1);
    no_beats();
    wb(1'b0, SDB_ADDR_STATUS, 32'h0);
    check(rd[5:0], 6'h20);
    wb(1'b1, SDB_ADDR_STATUS, 32'h1 << SDB_STATUS_ERR_BIT);
    wb(1'b0, SDB_ADDR_STATUS, 32'h0);
    check(rd[5], 0);
    ctrl_u.init(14'h0022, 14'h0055);
    check(o_ready, 1);
    wb(1'b0, SDB_ADDR_STATUS, 32'h0);
    check(rd[5:0], 6'h1F);
    wb(1'b0, SDB_ADDR_EXT, 32'h0);
    check(rd, 32'h55);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, SDB_ADDR_CONTROL, 32'h2);
    wb(1'b0, SDB_ADDR_CONTROL, 32'h0);
    check(rd[1:0], 2'h2);
    foreach (rows[j]) begin
      burst(rows[j]);
    end
    // A reserved size code must give no beats at all.
    ctrl_u.cmd(3'b000, SDB_BA_STD, 14'h0020, 1'b1);
    ctrl_u.nop(3);
    ctrl_u.cmd(3'b101, 2'h0, 14'h0003, 1'b1);
    no_beats();
    ctrl_u.cmd(3'b110, 2'h0, 14'h0000, 1'b0);
    ctrl_u.nop(2);
    check(o_ready, 0);
    wb(1'b0, SDB_ADDR_MODE, 32'h0);
    check(rd, 32'h0);
    ctrl_u.init(14'h0033, 14'h0000);
    check(o_ready, 1);
    burst(rows[1]);
    results();
  end
endmodule : sdb_core_tb
